/* File: cms_control_mode_selector.sv */
// auto/manual and remote/local mode selector with register slave
// What this block does
// RQ1: armed power-up self-tuning starts by itself after power returns.
// RQ2: single-run setting clears itself once new gains are computed and stored.
// RQ3: interrupted self-tuning keeps its setting and restarts when conditions allow.
// RQ4: each computed gain is multiplied by its factor, 0.01 to 10.00, default 1.00.
// RQ5: assigned auto/manual contact open holds manual and blocks key changes.
// RQ6: a setting chooses bumpless handover or stored output on entering manual.
// RQ7: bumpless handover seeds manual output with the last automatic output.
// RQ8: back in auto, control restarts from the manual output value.
// RQ9: on the auto/manual screen up selects manual, down returns to auto.
// RQ10: in stop the manual lamp stays dark.
// RQ11: each auto/manual toggle key press inverts the auto/manual selection.
// RQ12: auto/manual contact closed requests auto, open requests manual.
// RQ13: contact changes apply within 200 ms plus one 100 ms sampling cycle.
// RQ14: auto only if selection and contact both ask auto; manual lamp follows.
// RQ15: in manual up raises, down lowers the output; holding speeds it.
// RQ16: valve without feedback drives open or close only while a key is held.
// RQ17: assigned remote/local contact open holds local and blocks key changes.
// RQ18: on the remote/local screen up selects remote, down returns to local.
// RQ19: in stop the remote lamp stays dark.
// RQ20: remote/local toggle key works only with key type 2, inverting the mode.
// RQ21: remote/local contact closed requests remote, open requests local.
// RQ22: remote only if selection and contact both ask remote; lamp follows.
// RQ23: contacts must hold for over 200 ms; shorter activations are ignored.
// RQ24: key and host requests share one selection register, latest wins.
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"
module cms_control_mode_selector
	import cms_pkg::*;
#(
	parameter int GAIN_WIDTH = 16,
	parameter int MV_WIDTH = 12,
	parameter int MV_MAX = 1000,
	parameter int CONTACT_CYCLES = `CMS_T_CONTACT_MS * `CMS_CLK_KHZ,
	parameter int SAMPLE_CYCLES = `CMS_T_SAMPLE_MS * `CMS_CLK_KHZ,
	parameter int REPEAT_CYCLES = `CMS_T_KEY_REPEAT_MS * `CMS_CLK_KHZ
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// front keys, levels from panel scan logic on this clock
	input wire cms_keys_type keys,
	// contact pins, closed is high
	input wire logic am_contact,
	input wire logic rl_contact,
	// control loop side
	input wire logic [MV_WIDTH-1:0] auto_output,
	output logic [MV_WIDTH-1:0] manipulated_output,
	output logic output_visible,
	output logic loop_preset,
	output logic [MV_WIDTH-1:0] loop_preset_value,
	output logic open_drive,
	output logic close_drive,
	output cms_lamps_type lamps,
	output logic manual_active,
	output logic remote_active,
	// self-tuning engine
	input wire logic [1:0] stored_tune_setting,
	input wire logic tune_conditions_ok,
	input wire logic tune_done,
	input wire logic tune_interrupted,
	output logic tune_start,
	output logic tune_running,
	output logic [1:0] tune_setting,
	input wire logic [GAIN_WIDTH-1:0] computed_p,
	input wire logic [GAIN_WIDTH-1:0] computed_i,
	input wire logic [GAIN_WIDTH-1:0] computed_d,
	output logic [GAIN_WIDTH-1:0] gain_p,
	output logic [GAIN_WIDTH-1:0] gain_i,
	output logic [GAIN_WIDTH-1:0] gain_d
);
	initial
	begin
		if (MV_MAX >= (1 << MV_WIDTH) || GAIN_WIDTH < 4 || CONTACT_CYCLES < 1
			|| SAMPLE_CYCLES < 1 || REPEAT_CYCLES < 2)
			$error("cms_control_mode_selector: unusable parameters");
	end

	// ****
	// functions
	// ****
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = wd[8*b +: 8];
		return res;
	endfunction : merge

	function automatic logic [9:0] clamp_factor(input logic [31:0] v);
		logic [9:0] res;
		res = v[9:0];
		if (v > 32'({22'h0, `CMS_FACTOR_MAX}))
			res = `CMS_FACTOR_MAX;
		else if (v[9:0] < `CMS_FACTOR_MIN)
			res = `CMS_FACTOR_MIN;
		return res;
	endfunction : clamp_factor

	// factor is in hundredths; result saturates at full scale
	function automatic logic [GAIN_WIDTH-1:0] scale(input logic [GAIN_WIDTH-1:0] g,
		input logic [9:0] f);
		logic [GAIN_WIDTH+9:0] prod;
		logic [GAIN_WIDTH+9:0] quot;
		prod = g * f;
		quot = prod / (GAIN_WIDTH+10)'(`CMS_FACTOR_UNITY);
		if (quot > (GAIN_WIDTH+10)'({GAIN_WIDTH{1'b1}}))
			return {GAIN_WIDTH{1'b1}};
		return quot[GAIN_WIDTH-1:0];
	endfunction : scale

	// ****
	// axi4-lite slave
	// ****
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [6:0] ctrl;
	logic [1:0] mode_sel;
	logic [MV_WIDTH-1:0] stored_mv;
	logic [MV_WIDTH-1:0] manual_mv;
	logic [9:0] factor_p;
	logic [9:0] factor_i;
	logic [9:0] factor_d;
	logic [31:0] status_word;
	wire do_write = aw_full && w_full && !s_axi_bvalid;
	wire wr_ctrl = do_write && aw_addr == `CMS_OFF_CTRL;
	wire wr_mode = do_write && aw_addr == `CMS_OFF_MODE_REQ;
	wire wr_tune = do_write && aw_addr == `CMS_OFF_TUNE_CFG;
	wire wr_stored = do_write && aw_addr == `CMS_OFF_STORED_MV;
	wire wr_fp = do_write && aw_addr == `CMS_OFF_FACTOR_P;
	wire wr_fi = do_write && aw_addr == `CMS_OFF_FACTOR_I;
	wire wr_fd = do_write && aw_addr == `CMS_OFF_FACTOR_D;
	wire wr_hit = wr_ctrl || wr_mode || wr_tune || wr_stored || wr_fp || wr_fi || wr_fd;
	wire [31:0] mode_merged = merge({30'h0, mode_sel}, w_data, w_strb);
	wire [31:0] tune_merged = merge({30'h0, tune_setting}, w_data, w_strb);
	wire [31:0] ctrl_merged = merge({25'h0, ctrl}, w_data, w_strb);
	wire [31:0] stored_merged = merge({{(32-MV_WIDTH){1'b0}}, stored_mv}, w_data, w_strb);
	wire rd_go = s_axi_arvalid && s_axi_arready;
	logic [31:0] rd_word;
	logic rd_hit;
	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`CMS_OFF_CTRL: rd_word = {25'h0, ctrl};
			`CMS_OFF_MODE_REQ: rd_word = {30'h0, mode_sel};
			`CMS_OFF_STATUS: rd_word = status_word;
			`CMS_OFF_TUNE_CFG: rd_word = {30'h0, tune_setting};
			`CMS_OFF_STORED_MV: rd_word = {{(32-MV_WIDTH){1'b0}}, stored_mv};
			`CMS_OFF_MANUAL_MV: rd_word = {{(32-MV_WIDTH){1'b0}}, manual_mv};
			`CMS_OFF_FACTOR_P: rd_word = {22'h0, factor_p};
			`CMS_OFF_FACTOR_I: rd_word = {22'h0, factor_i};
			`CMS_OFF_FACTOR_D: rd_word = {22'h0, factor_d};
			default:
			begin
				rd_word = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end
	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CMS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full)
			begin
				aw_full <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_full)
			begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CMS_RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= `CMS_RST_CTRL;
			stored_mv <= `CMS_RST_MV;
			factor_p <= `CMS_RST_FACTOR;
			factor_i <= `CMS_RST_FACTOR;
			factor_d <= `CMS_RST_FACTOR;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= ctrl_merged[6:0];
			if (wr_stored)
				stored_mv <= stored_merged[MV_WIDTH-1:0];
			if (wr_fp)
				factor_p <= clamp_factor(merge({22'h0, factor_p}, w_data, w_strb)); // [RQ4]
			if (wr_fi)
				factor_i <= clamp_factor(merge({22'h0, factor_i}, w_data, w_strb)); // [RQ4]
			if (wr_fd)
				factor_d <= clamp_factor(merge({22'h0, factor_d}, w_data, w_strb)); // [RQ4]
		end
	end

	// ****
	// contact inputs: sync, filter, sample
	// ****
	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_s3;
	logic [1:0] filtered;
	logic [1:0] applied;
	logic [31:0] stable_cnt [2];
	logic [31:0] sample_cnt;
	wire sample_tick = sample_cnt == 32'(SAMPLE_CYCLES - 1);
	// a short activation restarts the count
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
			pin_s3 <= 2'h0;
			filtered <= 2'h0;
			stable_cnt[0] <= 32'h0000_0000;
			stable_cnt[1] <= 32'h0000_0000;
		end
		else
		begin
			pin_s1 <= {rl_contact, am_contact};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int c = 0; c < 2; c++)
			begin
				if (pin_s2[c] != pin_s3[c] || pin_s3[c] == filtered[c])
					stable_cnt[c] <= 32'h0000_0000; // [RQ23]
				else if (stable_cnt[c] >= 32'(CONTACT_CYCLES))
				begin
					filtered[c] <= pin_s3[c]; // [RQ23]
					stable_cnt[c] <= 32'h0000_0000;
				end
				else
					stable_cnt[c] <= stable_cnt[c] + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sample_cnt <= 32'h0000_0000;
			applied <= 2'h0;
		end
		else
		begin
			sample_cnt <= sample_tick ? 32'h0000_0000 : sample_cnt + 32'h0000_0001;
			if (sample_tick)
				applied <= filtered; // [RQ13]
		end
	end

	// ****
	// mode selection
	// ****
	cms_keys_type keys_q;
	wire run = ctrl[`CMS_CTRL_RUN];
	wire am_locked = ctrl[`CMS_CTRL_AM_ASSIGNED] && !applied[0];
	wire rl_locked = ctrl[`CMS_CTRL_RL_ASSIGNED] && !applied[1];
	wire up_edge = keys.up && !keys_q.up;
	wire down_edge = keys.down && !keys_q.down;
	wire am_edge = keys.am_toggle && !keys_q.am_toggle;
	wire rl_edge = keys.rl_toggle && !keys_q.rl_toggle;
	logic next_manual_sel;
	logic next_remote_sel;
	always_comb
	begin
		next_manual_sel = mode_sel[`CMS_MODE_REQ_MANUAL];
		next_remote_sel = mode_sel[`CMS_MODE_REQ_REMOTE];
		if (!am_locked) // [RQ5]
		begin
			if (keys.am_screen && up_edge)
				next_manual_sel = 1'b1; // [RQ9]
			else if (keys.am_screen && down_edge)
				next_manual_sel = 1'b0; // [RQ9]
			else if (am_edge)
				next_manual_sel = !mode_sel[`CMS_MODE_REQ_MANUAL]; // [RQ11]
		end
		if (!rl_locked) // [RQ17]
		begin
			if (keys.rl_screen && up_edge)
				next_remote_sel = 1'b1; // [RQ18]
			else if (keys.rl_screen && down_edge)
				next_remote_sel = 1'b0; // [RQ18]
			else if (rl_edge && ctrl[`CMS_CTRL_KEY_TYPE2])
				next_remote_sel = !mode_sel[`CMS_MODE_REQ_REMOTE]; // [RQ20]
		end
		if (wr_mode)
		begin
			// a host write beats a key in the same cycle
			next_manual_sel = mode_merged[`CMS_MODE_REQ_MANUAL]; // [RQ24]
			next_remote_sel = mode_merged[`CMS_MODE_REQ_REMOTE]; // [RQ24]
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			keys_q <= '0;
			mode_sel <= 2'h0;
		end
		else
		begin
			keys_q <= keys;
			mode_sel <= {next_remote_sel, next_manual_sel}; // [RQ24]
		end
	end
	// contact closed asks auto / remote; unassigned contact asks nothing
	assign manual_active = mode_sel[`CMS_MODE_REQ_MANUAL] || am_locked; // [RQ12] [RQ14]
	assign remote_active = mode_sel[`CMS_MODE_REQ_REMOTE] && !rl_locked; // [RQ21] [RQ22]
	assign lamps.hand_mode_lamp = manual_active && run; // [RQ10] [RQ14]
	assign lamps.external_sp_lamp = remote_active && run; // [RQ19] [RQ22]

	// ****
	// manual output value
	// ****
	logic manual_q;
	logic [31:0] hold_cnt;
	logic [3:0] repeats;
	wire valve_open_loop = ctrl[`CMS_CTRL_VALVE_MODE] && !ctrl[`CMS_CTRL_VALVE_FEEDBACK];
	wire key_held = keys.up ^ keys.down;
	wire repeat_tick = key_held && hold_cnt == 32'(REPEAT_CYCLES - 1);
	wire step_go = manual_active && !keys.am_screen && !keys.rl_screen
		&& ((key_held && (up_edge || down_edge)) || repeat_tick);
	wire [MV_WIDTH:0] step = (repeats >= 4'(`CMS_KEY_FAST_AFTER))
		? (MV_WIDTH+1)'(`CMS_KEY_FAST_STEP) : (MV_WIDTH+1)'(1); // [RQ15]
	wire [MV_WIDTH:0] mv_up = {1'b0, manual_mv} + step;
	wire [MV_WIDTH:0] mv_limit = (MV_WIDTH+1)'(MV_MAX);
	logic [MV_WIDTH-1:0] next_manual_mv;
	always_comb
	begin
		next_manual_mv = manual_mv;
		if (manual_active && !manual_q)
			next_manual_mv = ctrl[`CMS_CTRL_HANDOVER_SELECT]
				? stored_mv : auto_output; // [RQ6] [RQ7]
		else if (step_go && keys.up)
			next_manual_mv = (mv_up > mv_limit) ? MV_WIDTH'(MV_MAX) : mv_up[MV_WIDTH-1:0]; // [RQ15]
		else if (step_go && keys.down)
			next_manual_mv = ({1'b0, manual_mv} < step)
				? '0 : manual_mv - step[MV_WIDTH-1:0]; // [RQ15]
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			manual_q <= 1'b0;
			manual_mv <= `CMS_RST_MV;
			hold_cnt <= 32'h0000_0000;
			repeats <= 4'h0;
			loop_preset <= 1'b0;
			loop_preset_value <= `CMS_RST_MV;
		end
		else
		begin
			manual_q <= manual_active;
			manual_mv <= next_manual_mv;
			hold_cnt <= (!key_held || repeat_tick) ? 32'h0000_0000 : hold_cnt + 32'h0000_0001;
			if (!key_held)
				repeats <= 4'h0;
			else if (repeat_tick && repeats != 4'hF)
				repeats <= repeats + 4'h1; // [RQ15]
			loop_preset <= manual_q && !manual_active; // [RQ8]
			if (manual_q && !manual_active)
				loop_preset_value <= manual_mv; // [RQ8]
		end
	end
	// output follows the manual value directly, which takes the handover value one cycle after manual starts
	assign manipulated_output = manual_active ? manual_mv : auto_output;
	assign output_visible = !valve_open_loop; // [RQ16]
	assign open_drive = manual_active && valve_open_loop && keys.up && !keys.down; // [RQ16]
	assign close_drive = manual_active && valve_open_loop && keys.down && !keys.up; // [RQ16]

	// ****
	// power-up self-tuning
	// ****
	cms_tune_state_type tune_state;
	logic tune_loaded;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tune_loaded <= 1'b0;
			tune_state <= CMS_TUNE_IDLE;
			tune_setting <= `CMS_TUNE_OFF;
			tune_start <= 1'b0;
			gain_p <= '0;
			gain_i <= '0;
			gain_d <= '0;
		end
		else
		begin
			tune_loaded <= 1'b1;
			tune_start <= 1'b0;
			if (wr_tune)
				tune_setting <= tune_merged[1:0];
			case (tune_state)
				CMS_TUNE_IDLE:
					if (!tune_loaded)
					begin
						// the setting is kept outside; catch it once after power-up
						tune_setting <= stored_tune_setting;
						if (stored_tune_setting != `CMS_TUNE_OFF)
							tune_state <= CMS_TUNE_WAIT; // [RQ1]
					end
				CMS_TUNE_WAIT:
					if (tune_setting == `CMS_TUNE_OFF)
						tune_state <= CMS_TUNE_IDLE;
					else if (tune_conditions_ok)
					begin
						tune_start <= 1'b1; // [RQ1] [RQ3]
						tune_state <= CMS_TUNE_RUN;
					end
				CMS_TUNE_RUN:
					if (tune_done)
					begin
						gain_p <= scale(computed_p, factor_p); // [RQ4]
						gain_i <= scale(computed_i, factor_i); // [RQ4]
						gain_d <= scale(computed_d, factor_d); // [RQ4]
						if (tune_setting == `CMS_TUNE_ONCE)
							tune_setting <= `CMS_TUNE_OFF; // [RQ2]
						tune_state <= CMS_TUNE_IDLE;
					end
					else if (tune_interrupted)
						tune_state <= CMS_TUNE_WAIT; // [RQ3]
				default:
					tune_state <= CMS_TUNE_IDLE;
			endcase
		end
	end
	assign tune_running = tune_state == CMS_TUNE_RUN;
	assign status_word = {22'h0, output_visible, tune_running, close_drive, open_drive,
		applied, lamps.external_sp_lamp, lamps.hand_mode_lamp, remote_active, manual_active};
endmodule : cms_control_mode_selector
`default_nettype wire

/* File: cms_control_mode_selector_tb.sv */
// self-checking bench for the control mode selector
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"
module cms_control_mode_selector_tb
	import cms_pkg::*;
;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, tune_setting, stored_tune_setting;
	cms_keys_type keys;
	cms_lamps_type lamps;
	logic am_contact, rl_contact, output_visible, loop_preset, open_drive, close_drive;
	logic manual_active, remote_active, tune_start, tune_running;
	logic tune_conditions_ok, tune_done, tune_interrupted;
	logic [11:0] auto_output, manipulated_output, loop_preset_value;
	logic [15:0] computed_p, computed_i, computed_d, gain_p, gain_i, gain_d;
	int err_count = 0, compares = 0;
	cms_control_mode_selector #(.CONTACT_CYCLES(20), .SAMPLE_CYCLES(10), .REPEAT_CYCLES(4)) u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .keys, .am_contact, .rl_contact, .auto_output,
		.manipulated_output, .output_visible, .loop_preset, .loop_preset_value, .open_drive,
		.close_drive, .lamps, .manual_active, .remote_active, .stored_tune_setting,
		.tune_conditions_ok, .tune_done, .tune_interrupted, .tune_start, .tune_running,
		.tune_setting, .computed_p, .computed_i, .computed_d, .gain_p, .gain_i, .gain_d);
	cms_panel_model #(.HOLD(20)) u_p (.aclk, .keys, .am_contact, .rl_contact);
	always #5 aclk = ~aclk;
	task ck(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : ck
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task tend(input string n);
		$display("test %s done", n);
	endtask : tend
	task tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#200000;
		err_count++;
		tally_and_finish();
	end
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{tune_conditions_ok, tune_done, tune_interrupted, s_axi_wstrb} = 7'h0F;
		{stored_tune_setting, auto_output} = {`CMS_TUNE_ONCE, 12'h12C};
		{computed_p, computed_i, computed_d} = {16'h00C8, 16'h000A, 16'h0007};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`CMS_OFF_FACTOR_D, d, r);
		ck("factor_d", 32'h0000_0064, d);
		rd(8'h40, d, r);
		ck("bad_resp", `CMS_RESP_SLVERR, r);
		ck("armed", `CMS_TUNE_ONCE, tune_setting);
		tune_conditions_ok <= 1'b1;
		repeat (4) @(posedge aclk);
		ck("running", 1, tune_running);
		tune_interrupted <= 1'b1;
		tune_conditions_ok <= 1'b0;
		@(posedge aclk);
		tune_interrupted <= 1'b0;
		repeat (2) @(posedge aclk);
		ck("kept", `CMS_TUNE_ONCE, tune_setting);
		tune_conditions_ok <= 1'b1;
		repeat (4) @(posedge aclk);
		ck("restart", 1, tune_running);
		s_axi_wstrb <= 4'h1;
		wr(`CMS_OFF_FACTOR_P, 32'h0000_0332);
		s_axi_wstrb <= 4'hF;
		wr(`CMS_OFF_FACTOR_I, 32'h0000_07D0);
		rd(`CMS_OFF_FACTOR_I, d, r);
		ck("factor_i", 32'h0000_03E8, d);
		tune_done <= 1'b1;
		@(posedge aclk);
		tune_done <= 1'b0;
		repeat (2) @(posedge aclk);
		ck("gain_p", 16'h0064, gain_p);
		ck("gain_i", 16'h0064, gain_i);
		ck("gain_d", 16'h0007, gain_d);
		ck("cleared", `CMS_TUNE_OFF, tune_setting);
		tend("tuning");
		wr(`CMS_OFF_CTRL, 32'h0000_0001);
		u_p.press(6'h22);
		ck("lamp", 1, lamps.hand_mode_lamp);
		ck("bumpless", 12'h12C, manipulated_output);
		auto_output <= 12'h1F4;
		u_p.press(6'h20);
		ck("up", 12'h12D, manipulated_output);
		u_p.press(6'h10);
		u_p.press(6'h12);
		ck("auto", 0, manual_active);
		ck("preset", 12'h12C, loop_preset_value);
		u_p.press(6'h08);
		ck("toggle", 1, manual_active);
		wr(`CMS_OFF_CTRL, 32'h0000_0000);
		ck("stop_lamp", 0, lamps.hand_mode_lamp);
		wr(`CMS_OFF_STORED_MV, 32'h0000_007B);
		wr(`CMS_OFF_CTRL, 32'h0000_0003);
		u_p.press(6'h08);
		u_p.press(6'h08);
		ck("stored", 12'h07B, manipulated_output);
		u_p.set(6'h20);
		repeat (50) @(posedge aclk);
		u_p.set(6'h00);
		repeat (2) @(posedge aclk);
		ck("fast", 1, manipulated_output > 12'h08B);
		wr(`CMS_OFF_CTRL, 32'h0000_000B);
		u_p.set(6'h20);
		repeat (2) @(posedge aclk);
		ck("open", 1, open_drive);
		ck("hidden", 0, output_visible);
		u_p.set(6'h10);
		repeat (2) @(posedge aclk);
		ck("close", 1, close_drive);
		wr(`CMS_OFF_CTRL, 32'h0000_001B);
		ck("shown", 1, output_visible);
		u_p.set(6'h00);
		tend("manual");
		wr(`CMS_OFF_CTRL, 32'h0000_0001);
		wr(`CMS_OFF_MODE_REQ, 32'h0000_0000);
		ck("host", 0, manual_active);
		u_p.press(6'h08);
		rd(`CMS_OFF_MODE_REQ, d, r);
		ck("mode_req", 32'h0000_0001, d);
		u_p.press(6'h04);
		ck("type1", 0, remote_active);
		wr(`CMS_OFF_CTRL, 32'h0000_0005);
		u_p.press(6'h04);
		ck("rem_lamp", 1, lamps.external_sp_lamp);
		u_p.press(6'h11);
		ck("local", 0, remote_active);
		u_p.press(6'h21);
		ck("remote", 1, remote_active);
		wr(`CMS_OFF_CTRL, 32'h0000_0004);
		ck("rem_stop", 0, lamps.external_sp_lamp);
		tend("modes");
		wr(`CMS_OFF_CTRL, 32'h0000_0065);
		u_p.press(6'h08);
		ck("am_closed", 0, manual_active);
		u_p.contact(1'b0, 1'b0);
		repeat (16) @(posedge aclk);
		ck("am_open", 1, manual_active);
		ck("rl_open", 0, remote_active);
		u_p.press(6'h08);
		u_p.press(6'h11);
		u_p.glitch();
		repeat (40) @(posedge aclk);
		ck("glitch", 1, manual_active);
		u_p.contact(1'b1, 1'b1);
		repeat (16) @(posedge aclk);
		ck("am_lock", 0, manual_active);
		ck("rl_lock", 1, remote_active);
		tend("contacts");
		tally_and_finish();
	end
endmodule : cms_control_mode_selector_tb
bind cms_control_mode_selector cms_selector_checker #(.GAIN_WIDTH(GAIN_WIDTH),
	.MV_WIDTH(MV_WIDTH)) u_chk (.aclk, .aresetn, .keys, .auto_output, .manipulated_output,
	.loop_preset, .open_drive, .close_drive, .lamps, .manual_active, .remote_active,
	.tune_done, .tune_interrupted, .tune_start, .tune_running, .tune_setting, .gain_p);
`default_nettype wire

/* File: cms_defines.svh */
// constants for the control mode selector: offsets, fields, resets, times
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH
// ****
// register byte offsets
// ****
`define CMS_OFF_CTRL 8'h00
`define CMS_OFF_MODE_REQ 8'h04
`define CMS_OFF_STATUS 8'h08
`define CMS_OFF_TUNE_CFG 8'h0C
`define CMS_OFF_STORED_MV 8'h10
`define CMS_OFF_MANUAL_MV 8'h14
`define CMS_OFF_FACTOR_P 8'h18
`define CMS_OFF_FACTOR_I 8'h1C
`define CMS_OFF_FACTOR_D 8'h20
// ****
// control register fields
// ****
`define CMS_CTRL_RUN 0
`define CMS_CTRL_HANDOVER_SELECT 1
`define CMS_CTRL_KEY_TYPE2 2
`define CMS_CTRL_VALVE_MODE 3
`define CMS_CTRL_VALVE_FEEDBACK 4
`define CMS_CTRL_AM_ASSIGNED 5
`define CMS_CTRL_RL_ASSIGNED 6
`define CMS_CTRL_WIDTH 7
`define CMS_MODE_REQ_MANUAL 0
`define CMS_MODE_REQ_REMOTE 1
// ****
// reset values
// ****
`define CMS_RST_CTRL 7'h00
`define CMS_RST_FACTOR 10'h064
`define CMS_FACTOR_MIN 10'h001
`define CMS_FACTOR_MAX 10'h3E8
`define CMS_FACTOR_UNITY 100
`define CMS_RST_MV 12'h000
// ****
// self-tuning settings
// ****
`define CMS_TUNE_OFF 2'h0
`define CMS_TUNE_ONCE 2'h1
`define CMS_TUNE_ALWAYS 2'h2
// ****
// timing
// ****
`define CMS_CLK_KHZ 100000
`define CMS_T_CONTACT_MS 200
`define CMS_T_SAMPLE_MS 100
`define CMS_T_KEY_REPEAT_MS 200
`define CMS_KEY_FAST_AFTER 8
`define CMS_KEY_FAST_STEP 10
`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_SLVERR 2'h2
`endif

/* File: cms_panel_model.sv */
// panel keys and contact pins driven towards the selector
`timescale 1ns/1ps
`default_nettype none
module cms_panel_model
	import cms_pkg::*;
#(
	parameter int HOLD = 20
)
(
	// clock
	input wire logic aclk,
	// panel side
	output cms_keys_type keys,
	output logic am_contact,
	output logic rl_contact
);
	initial
	begin
		keys = '0;
		am_contact = 1'b1;
		rl_contact = 1'b1;
	end
	task set(input cms_keys_type k);
		@(posedge aclk);
		keys <= k;
	endtask : set
	// press: two cycles held, two released
	task press(input cms_keys_type k);
		set(k);
		repeat (2) @(posedge aclk);
		keys <= '0;
		repeat (2) @(posedge aclk);
	endtask : press
	// held past the filter time so the change counts
	task contact(input logic a, input logic r);
		@(posedge aclk);
		am_contact <= a;
		rl_contact <= r;
		repeat (HOLD + 1) @(posedge aclk);
	endtask : contact
	// deliberately too short
	task glitch();
		@(posedge aclk);
		am_contact <= ~am_contact;
		repeat (HOLD / 2) @(posedge aclk);
		am_contact <= ~am_contact;
	endtask : glitch
endmodule : cms_panel_model
`default_nettype wire

/* File: cms_pkg.sv */
// types shared by the control mode selector
`default_nettype none
package cms_pkg;
	typedef struct packed {
		logic up;
		logic down;
		logic am_toggle;
		logic rl_toggle;
		logic am_screen;
		logic rl_screen;
	} cms_keys_type;
	typedef struct packed {
		logic hand_mode_lamp;
		logic external_sp_lamp;
	} cms_lamps_type;
	typedef enum logic [1:0] {
		CMS_TUNE_IDLE,
		CMS_TUNE_WAIT,
		CMS_TUNE_RUN
	} cms_tune_state_type;
endpackage : cms_pkg
`default_nettype wire

/* File: cms_selector_assertions.sv */
// port assertions for the control mode selector
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"
module cms_selector_checker
	import cms_pkg::*;
#(
	parameter int GAIN_WIDTH = 16,
	parameter int MV_WIDTH = 12
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// panel and loop
	input wire cms_keys_type keys,
	input wire logic [MV_WIDTH-1:0] auto_output,
	input wire logic [MV_WIDTH-1:0] manipulated_output,
	input wire logic loop_preset,
	input wire logic open_drive,
	input wire logic close_drive,
	input wire cms_lamps_type lamps,
	input wire logic manual_active,
	input wire logic remote_active,
	// self-tuning
	input wire logic tune_done,
	input wire logic tune_interrupted,
	input wire logic tune_start,
	input wire logic tune_running,
	input wire logic [1:0] tune_setting,
	input wire logic [GAIN_WIDTH-1:0] gain_p
);
	wire logic once_done = tune_done && tune_running && tune_setting == `CMS_TUNE_ONCE;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_HAND: assert property (lamps.hand_mode_lamp |-> manual_active)
		else $error("hand lamp");
	AST_REM: assert property (lamps.external_sp_lamp |-> remote_active)
		else $error("remote lamp");
	AST_AUTO: assert property (!manual_active |-> manipulated_output == auto_output)
		else $error("auto output");
	AST_OPEN: assert property (open_drive |-> keys.up && !keys.down && manual_active)
		else $error("open drive");
	AST_CLOSE: assert property (close_drive |-> keys.down && !keys.up && manual_active)
		else $error("close drive");
	// preset is registered, so it may trail the mode by one edge
	AST_PRESET: assert property ($fell(manual_active) |-> ##[0:1] loop_preset)
		else $error("no preset");
	AST_START: assert property (tune_start |-> ##[0:1] tune_running)
		else $error("no tuning");
	AST_CLEAR: assert property (once_done |-> ##[1:2] tune_setting == `CMS_TUNE_OFF)
		else $error("setting kept");
	AST_KEEP: assert property (tune_interrupted |=> tune_setting == $past(tune_setting))
		else $error("setting lost");
	AST_GAIN: assert property (!$past(tune_done) |-> $stable(gain_p))
		else $error("gain moved");
	cover property (tune_start);
	cover property ($rose(manual_active));
	cover property (open_drive);
endmodule : cms_selector_checker
`default_nettype wire
